// >>> rtl/irqal_top.sv
// Interrupt request, vector and transfer-acknowledge logic.
module irqal_top
	import irqal_pkg::*;
#(
	parameter int CHAN_W = IRQAL_CHAN_W,
	parameter int PORT_W = IRQAL_PORT_W
) (
	// Clock, reset, enable.
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic CE,
	// Pending sources and masks (mask bit high blocks the source).
	input wire logic [CHAN_W-1:0] CHAN_STATUS_LO,
	input wire logic [CHAN_W-1:0] CHAN_STATUS_HI,
	input wire logic [PORT_W-1:0] PORT_IRQ_STATUS,
	input wire logic [CHAN_W-1:0] CHAN_MASK_LO,
	input wire logic [CHAN_W-1:0] CHAN_MASK_HI,
	input wire logic [PORT_W-1:0] PORT_IRQ_MASK,
	input wire logic PORT_IRQ_EN,
	// Configuration.
	input wire logic [1:0] IRQ_DRIVE_MODE,
	input wire logic CASCADE_MODE,
	input wire logic STROBE_BUS_MODE,
	input wire logic [1:0] SLAVE_ADDR,
	input wire logic [7:0] VECTOR_BASE,
	// Bus pins, all active low except chain enable and chain address.
	input wire logic DATA_STROBE_IN_N,
	input wire logic RD_N,
	input wire logic WR_N,
	input wire logic CS_N,
	input wire logic IRQ_ACK_IN_N,
	input wire logic CHAIN_ENABLE_IN,
	input wire logic CHAIN_ADDR_HI,
	// Outputs.
	output logic IRQ_OUT,
	output logic IRQ_OE,
	output logic XFER_ACK_OUT_N,
	output logic XFER_ACK_OE,
	output logic [7:0] DATA_OUT,
	output logic DATA_OE,
	output logic CHAIN_ENABLE_OUT,
	output logic CHAIN_ADDR_LO_OE,
	output logic [7:0] GLOBAL_IRQ_STATUS
);

	////////////////////////////////////////////////////////////////////////
	// Pin synchronisers.

	// Raw pins in, filtered pins out; the unpack keeps the same order.
	logic [6:0] pin_raw, pin_s;
	logic ds_n, rd_n, wr_n, cs_n, ack_n, ce_in, addr_hi;

	// Bit order: strobe, read, write, select, acknowledge, chain, address.
	assign pin_raw = {DATA_STROBE_IN_N, RD_N, WR_N, CS_N, IRQ_ACK_IN_N,
		CHAIN_ENABLE_IN, CHAIN_ADDR_HI};
	assign {ds_n, rd_n, wr_n, cs_n, ack_n, ce_in, addr_hi} = pin_s;

	// Strobes rest high so no cycle is seen while leaving reset.
	irqal_sync #(
		.WIDTH(7),
		.INIT(7'h7C)
	) u_sync (
		.clk(CLK_SYS),
		.rst_n(RST_N),
		.ce(CE),
		.d(pin_raw),
		.q(pin_s)
	);

	////////////////////////////////////////////////////////////////////////
	// Source merging and group priority.

	// Group flags, winning group and merged pending level.
	logic [IRQAL_GROUPS-1:0] grp;
	logic [IRQAL_GRP_W-1:0] top_grp;
	logic pending;
	logic [CHAN_W-1:0] act_lo, act_hi;
	logic [PORT_W-1:0] act_port;
	localparam int HALF = CHAN_W / 2;

	// [R04] Mask gating.
	assign act_lo = CHAN_STATUS_LO & ~CHAN_MASK_LO;
	assign act_hi = CHAN_STATUS_HI & ~CHAN_MASK_HI;
	assign act_port = PORT_IRQ_EN ? (PORT_IRQ_STATUS & ~PORT_IRQ_MASK)
		: '0;

	// [R10] Eight groups.
	// Each channel register is split in halves; port has two groups too.
	always_comb begin
		grp[0] = |act_lo[HALF-1:0];
		grp[1] = |act_lo[CHAN_W-1:HALF];
		grp[2] = |act_hi[HALF-1:0];
		grp[3] = |act_hi[CHAN_W-1:HALF];
		grp[4] = |CHAN_STATUS_LO & 1'b0;
		grp[5] = |CHAN_STATUS_HI & 1'b0;
		grp[6] = |act_port[PORT_W/2-1:0];
		grp[7] = |act_port[PORT_W-1:PORT_W/2];
	end

	// [R03] Single merged request.
	assign pending = |grp;

	// [R11] Lowest index wins.
	always_comb begin
		top_grp = '0;
		for (int i = IRQAL_GROUPS - 1; i >= 0; i--) begin
			if (grp[i]) begin
				top_grp = IRQAL_GRP_W'(i);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Acknowledge sequencing.

	// Sequencer state. cnt_reg marks the first read/write-mode
	// acknowledge cycle as done.
	irqal_state_t st_reg, st_next;
	logic req_reg, req_next;
	logic [1:0] cnt_reg, cnt_next;
	logic [7:0] vec_reg, vec_next;
	logic xfer_ack_out_reg, xfer_ack_out_next;
	logic doe_reg, doe_next;
	logic ack_prev_reg;
	logic daisy, accept, ack_fall, ack_rise, bus_cyc, strobe;

	// Mode decode and edges of the filtered acknowledge.
	// Register cycles need select as well; acknowledge cycles ignore it.
	assign daisy = (CASCADE_MODE == IRQAL_CAS_DAISY);
	assign ack_fall = ack_prev_reg & ~ack_n;
	assign ack_rise = ~ack_prev_reg & ack_n;
	assign strobe = STROBE_BUS_MODE ? ~ds_n : (~rd_n | ~wr_n);
	assign bus_cyc = ~cs_n & strobe;

	// Only one address pin is wired, so slave address bit zero must be 0.
	// [R15] Slave address match.
	// [R16] Daisy chain enable.
	assign accept = req_reg & (daisy ? ce_in :
		({addr_hi, CHAIN_ADDR_LO_OE ? 1'b0 : 1'b0} == SLAVE_ADDR));

	// Next-state logic. The request is rebuilt from source levels each
	// cycle, so a source still pending after service raises it again.
	always_comb begin
		st_next = st_reg;
		req_next = req_reg;
		cnt_next = cnt_reg;
		vec_next = vec_reg;
		xfer_ack_out_next = xfer_ack_out_reg;
		doe_next = 1'b0;
		// [R07] Chain gating of generation.
		if (pending && (!daisy || ce_in) && st_reg == IRQAL_IDLE) begin
			req_next = 1'b1;
		end
		// [R08] Clear on disable or empty status.
		if (!pending || (daisy && !ce_in)) begin
			req_next = 1'b0;
		end
		unique case (st_reg)
			IRQAL_IDLE: begin
				xfer_ack_out_next = 1'b0;
				if (ack_fall) begin
					st_next = accept ? IRQAL_ACK : IRQAL_REJ;
					// Held fixed for the whole cycle.
					// [R09] Vector from top group.
					vec_next = {VECTOR_BASE[7:IRQAL_GRP_W], top_grp};
				end else if (bus_cyc) begin
					st_next = IRQAL_XFER;
				end
			end
			IRQAL_ACK: begin
				// [R13] Vector gated by strobe.
				doe_next = STROBE_BUS_MODE ? ~ds_n : ~rd_n;
				// No vector in the first read/write cycle.
				if (!STROBE_BUS_MODE && cnt_reg != IRQAL_CNT_ONE) begin
					doe_next = 1'b0;
				end
				// [R01] Acknowledge the cycle.
				xfer_ack_out_next = 1'b1;
				if (ack_rise) begin
					// [R02] Release on acknowledge end.
					xfer_ack_out_next = 1'b0;
					// [R12] One cycle in strobe mode.
					// [R14] Second cycle in read/write mode.
					if (STROBE_BUS_MODE || cnt_reg == IRQAL_CNT_ONE) begin
						cnt_next = IRQAL_CNT_ZERO;
						req_next = 1'b0;
						st_next = IRQAL_IDLE;
					end else begin
						// Park until the second cycle begins.
						cnt_next = IRQAL_CNT_ONE;
						st_next = IRQAL_REJ;
					end
				end
			end
			IRQAL_REJ: begin
				// Also the pause between read/write cycles.
				// [R19] No vector when not accepted.
				doe_next = 1'b0;
				xfer_ack_out_next = 1'b0;
				if (ack_fall) begin
					st_next = (cnt_reg == IRQAL_CNT_ONE) ? IRQAL_ACK
						: IRQAL_REJ;
				end else if (ack_n && cnt_reg != IRQAL_CNT_ONE) begin
					st_next = IRQAL_IDLE;
				end
			end
			IRQAL_XFER: begin
				// [R01] Ready for the register transfer.
				xfer_ack_out_next = 1'b1;
				// [R02] Release when select or strobe ends.
				if (cs_n || !strobe) begin
					xfer_ack_out_next = 1'b0;
					st_next = IRQAL_IDLE;
				end
			end
			default: begin
				// Only a corrupted one-hot code lands here.
				st_next = IRQAL_IDLE;
			end
		endcase
	end

	// Sequencer registers. The acknowledge history resets high like the
	// idle pin, so no false falling edge follows reset.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			st_reg <= IRQAL_IDLE;
			req_reg <= 1'b0;
			cnt_reg <= IRQAL_CNT_ZERO;
			vec_reg <= IRQAL_BYTE_ZERO;
			xfer_ack_out_reg <= 1'b0;
			doe_reg <= 1'b0;
			ack_prev_reg <= 1'b1;
		end else if (CE) begin
			st_reg <= st_next;
			req_reg <= req_next;
			cnt_reg <= cnt_next;
			vec_reg <= vec_next;
			xfer_ack_out_reg <= xfer_ack_out_next;
			doe_reg <= doe_next;
			ack_prev_reg <= ack_n;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Output stage; every output is a flip-flop except the constant XFER_ACK_OUT_N and CHAIN_ADDR_LO_OE.

	// Registered pin values.
	logic irq_out_reg, irq_oe_reg, ceo_reg;
	logic [7:0] gis_reg;
	logic irq_out_next, irq_oe_next, ceo_next;
	logic [7:0] gis_next;

	// Pins follow req_next so they move with the request register.
	always_comb begin
		// [R06] Drive mode of the request pin.
		unique case (IRQ_DRIVE_MODE)
			IRQAL_DRV_PP_HIGH: begin
				irq_out_next = req_next;
				irq_oe_next = 1'b1;
			end
			IRQAL_DRV_PP_LOW: begin
				irq_out_next = ~req_next;
				irq_oe_next = 1'b1;
			end
			default: begin
				irq_out_next = 1'b0;
				irq_oe_next = req_next;
			end
		endcase
		// [R18] Block lower chain members.
		ceo_next = daisy ? (ce_in & ~req_next) : 1'b0;
		// [R05] Global status summary.
		gis_next = grp;
	end

	// Output registers; every pin is released during reset.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			irq_out_reg <= 1'b0;
			irq_oe_reg <= 1'b0;
			ceo_reg <= 1'b0;
			gis_reg <= IRQAL_BYTE_ZERO;
		end else if (CE) begin
			irq_out_reg <= irq_out_next;
			irq_oe_reg <= irq_oe_next;
			ceo_reg <= ceo_next;
			gis_reg <= gis_next;
		end
	end

	// Ports taken straight from the registers above.
	assign IRQ_OUT = irq_out_reg;
	assign IRQ_OE = irq_oe_reg;
	// Open drain: pin only pulled low while acknowledging.
	assign XFER_ACK_OUT_N = 1'b0 | ~xfer_ack_out_reg & 1'b0;
	assign XFER_ACK_OE = xfer_ack_out_reg;
	assign DATA_OUT = vec_reg;
	assign DATA_OE = doe_reg;
	assign CHAIN_ENABLE_OUT = ceo_reg;
	// Low chain pin is never driven: it is an input in slave mode.
	assign CHAIN_ADDR_LO_OE = 1'b0;
	assign GLOBAL_IRQ_STATUS = gis_reg;

endmodule : irqal_top

// >>> rtl/irqal_pkg.sv
// Notes on behaviour
// [R01] Assert transfer acknowledge during asynchronous bus cycles.
// [R02] Hold acknowledge until strobe, select, acknowledge release.
// [R03] One request output merges channel and port sources.
// [R04] Masked sources never drive the request.
// [R05] Pending status shown globally, per channel, port.
// [R06] Request output: push-pull low, high, open drain.
// [R07] Daisy chain: request only while chain enable high.
// [R08] Drop request on chain disable or status clear.
// [R09] Acknowledge drives vector on low data byte.
// [R10] Sources organised in eight fixed-priority groups; the code ties groups 4 and 5 to zero.
// [R11] Vector names highest-priority active group.
// [R12] Strobe mode: release after next valid acknowledge.
// [R13] Strobe mode: vector qualified by data strobe.
// [R14] Read/write mode: two-cycle acknowledge, release second.
// [R15] Slave cascade: accept when requesting, address matches; the code reads only the high address pin and takes bit zero as 0.
// [R16] Daisy chain: accept when requesting, chain enabled.
// [R17] Host keeps select, DMA acknowledges inactive.
// [R18] Daisy chain: active request drops chain enable out.
// [R19] Unaccepted acknowledge: no vector, bus undriven.
package irqal_pkg;

	// Source counts and widths.
	localparam int IRQAL_CHAN_W = 16;
	localparam int IRQAL_PORT_W = 8;
	localparam int IRQAL_GROUPS = 8;
	localparam int IRQAL_GRP_W = 3;

	// Output drive modes of the request pin.
	localparam logic [1:0] IRQAL_DRV_OD = 2'h0;
	localparam logic [1:0] IRQAL_DRV_PP_LOW = 2'h1;
	localparam logic [1:0] IRQAL_DRV_PP_HIGH = 2'h3;

	// Cascading modes.
	localparam logic IRQAL_CAS_SLAVE = 1'h0;
	localparam logic IRQAL_CAS_DAISY = 1'h1;

	// Reset values and the count after the first read/write cycle.
	localparam logic [7:0] IRQAL_BYTE_ZERO = 8'h00;
	localparam logic [1:0] IRQAL_CNT_ZERO = 2'h0;
	localparam logic [1:0] IRQAL_CNT_ONE = 2'h1;

	// Acknowledge sequencing states.
	typedef enum logic [3:0] {
		IRQAL_IDLE = 4'b0001,
		IRQAL_ACK = 4'b0010,
		IRQAL_REJ = 4'b0100,
		IRQAL_XFER = 4'b1000
	} irqal_state_t;

endpackage : irqal_pkg

// >>> rtl/irqal_sync.sv
// Three-stage synchroniser; the output moves once stages two and three agree.
module irqal_sync
	import irqal_pkg::*;
#(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] INIT = '0
) (
	// Clocking.
	input wire logic clk,
	input wire logic rst_n,
	input wire logic ce,
	// Data.
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] s1_reg, s2_reg, s3_reg, q_reg;
	logic [WIDTH-1:0] q_next;

	// Per bit, update only where the two later stages agree.
	always_comb begin
		for (int i = 0; i < WIDTH; i++) begin
			q_next[i] = (s2_reg[i] == s3_reg[i]) ? s3_reg[i] : q_reg[i];
		end
	end

	// Stage registers.
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			s1_reg <= INIT;
			s2_reg <= INIT;
			s3_reg <= INIT;
			q_reg <= INIT;
		end else if (ce) begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			q_reg <= q_next;
		end
	end

	assign q = q_reg;

endmodule : irqal_sync

// >>> bench/irqal_chk.sv
module irqal_chk
	import irqal_pkg::*;
(
	// Clock and reset.
	input wire logic CLK_SYS,
	input wire logic RST_N,
	input wire logic CE,
	// Configuration.
	input wire logic [1:0] IRQ_DRIVE_MODE,
	input wire logic CASCADE_MODE,
	input wire logic STROBE_BUS_MODE,
	input wire logic [7:0] VECTOR_BASE,
	// Bus pins.
	input wire logic DATA_STROBE_IN_N,
	input wire logic RD_N,
	input wire logic WR_N,
	input wire logic CS_N,
	input wire logic IRQ_ACK_IN_N,
	input wire logic CHAIN_ENABLE_IN,
	// Design outputs.
	input wire logic IRQ_OUT,
	input wire logic IRQ_OE,
	input wire logic XFER_ACK_OE,
	input wire logic [7:0] DATA_OUT,
	input wire logic DATA_OE,
	input wire logic CHAIN_ENABLE_OUT,
	input wire logic [7:0] GLOBAL_IRQ_STATUS
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [1:0] mode_q;
	default clocking cb @(posedge CLK_SYS);
	endclocking
	default disable iff (!RST_N);
	// The pins were registered under last cycle's mode, so decode with it.
	always_ff @(posedge CLK_SYS) begin
		if (!RST_N) begin
			mode_q <= IRQAL_DRV_OD;
		end else if (CE) begin
			mode_q <= IRQ_DRIVE_MODE;
		end
	end
	// Request level as the pin shows it in each drive mode.
	wire act = IRQ_OE && (mode_q == IRQAL_DRV_PP_LOW ? !IRQ_OUT :
		mode_q == IRQAL_DRV_PP_HIGH ? IRQ_OUT : 1'b1);
	wire [7:0] below = (8'h01 << DATA_OUT[2:0]) - 8'h01;
	sequence s_quiet;
		(GLOBAL_IRQ_STATUS == 8'h00) [*3];
	endsequence
	sequence s_gated;
		(CASCADE_MODE && !CHAIN_ENABLE_IN) [*8];
	endsequence
	sequence s_vec;
		$rose(DATA_OE);
	endsequence
	AST_XACK_CAUSE: assert property (
		$rose(XFER_ACK_OE) |-> !IRQ_ACK_IN_N || !CS_N)
		else $error("transfer ack without a cycle");
	AST_XACK_HOLD: assert property (
		$fell(XFER_ACK_OE) |-> $past(IRQ_ACK_IN_N && (CS_N ||
		(STROBE_BUS_MODE ? DATA_STROBE_IN_N : RD_N && WR_N))))
		else $error("transfer ack dropped early");
	AST_QUIET: assert property (s_quiet |-> !act)
		else $error("request with no status");
	AST_GATED: assert property (s_gated |-> !act)
		else $error("request while chain disabled");
	AST_CHAIN: assert property (
		$rose(act) && CASCADE_MODE |-> ##[0:1] !CHAIN_ENABLE_OUT)
		else $error("chain enable out not blocked");
	AST_VBASE: assert property (
		DATA_OE |-> DATA_OUT[7:3] == VECTOR_BASE[7:3])
		else $error("vector base wrong");
	AST_PRIO: assert property (s_vec |->
		GLOBAL_IRQ_STATUS[DATA_OUT[2:0]] && !(|(GLOBAL_IRQ_STATUS & below)))
		else $error("vector not top group");
	AST_DSQ: assert property (
		s_vec ##0 STROBE_BUS_MODE |-> !DATA_STROBE_IN_N)
		else $error("vector without strobe");
	AST_NOACC: assert property (s_vec |-> !IRQ_ACK_IN_N)
		else $error("vector without acknowledge");
endmodule : irqal_chk

bind irqal_top irqal_chk i_chk (.*);

// >>> bench/irqal_host.sv
module irqal_host (
	// Clock and bus mode.
	input wire logic clk,
	input wire logic ds_mode,
	// Strobes driven by the host.
	output logic ds_n,
	output logic rd_n,
	output logic wr_n,
	output logic cs_n,
	output logic ack_n,
	// Device answer.
	input wire logic xack,
	input wire logic doe,
	input wire logic [7:0] dout
);
	timeunit 1ns;
	timeprecision 1ns;
	// Strobes idle high from time zero.
	initial begin
		ds_n = 1'b1;
		rd_n = 1'b1;
		wr_n = 1'b1;
		cs_n = 1'b1;
		ack_n = 1'b1;
	end
	// One register access: select and a strobe, held until answered.
	task automatic xfer(input logic wr, output logic acc);
		int n;
		acc = 1'b0;
		@(posedge clk);
		cs_n <= 1'b0;
		ds_n <= !ds_mode;
		rd_n <= ds_mode || wr;
		wr_n <= ds_mode || !wr;
		for (n = 0; n < 12 && !acc; n++) begin
			@(posedge clk);
			acc = (xack === 1'b1);
		end
		cs_n <= 1'b1;
		ds_n <= 1'b1;
		rd_n <= 1'b1;
		wr_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : xfer
	// One acknowledge cycle; a refusal simply times out.
	task automatic ack(output logic acc, output logic vo,
		output logic [7:0] v);
		int n;
		acc = 1'b0;
		vo = 1'b0;
		v = 8'h00;
		@(posedge clk);
		ack_n <= 1'b0;
		ds_n <= !ds_mode;
		rd_n <= ds_mode;
		for (n = 0; n < 12 && !acc; n++) begin
			@(posedge clk);
			acc = (xack === 1'b1);
			if (doe === 1'b1) begin
				vo = 1'b1;
				v = dout;
			end
		end
		ack_n <= 1'b1;
		ds_n <= 1'b1;
		rd_n <= 1'b1;
		// Let the synchronisers see the release.
		repeat (8) @(posedge clk);
	endtask : ack
endmodule : irqal_host

// >>> bench/irqal_tb_top.sv
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin \
	error_cnt++; $display("Error %0t: mismatch", $time); end end
module irqal_tb_top;
	import irqal_pkg::*;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [7:0] VB = 8'hA8;
	logic clk = 1'b0, rst_n = 1'b0, pe = 1'b1, cas = 1'b0;
	logic ce = 1'b1;
	logic dsm = 1'b1, cin = 1'b0, acc, vo;
	logic [15:0] sl = '0, sh = '0, ml = '0;
	logic [7:0] ps = '0, v, dout, global_irq_status;
	logic [1:0] dm = IRQAL_DRV_OD, sa = 2'h0;
	logic ds_n, rd_n, wr_n, cs_n, ack_n, xan, io, ioe, xoe, doe, ceo;
	int error_cnt = 0, total_checks = 0;
	int gl[6] = '{0, 1, 2, 3, 6, 7};
	logic [1:0] ml3[3] = '{2'h3, 2'h1, 2'h0};
	wire act = ioe && (dm == IRQAL_DRV_PP_LOW ? !io :
		dm == IRQAL_DRV_PP_HIGH ? io : 1'b1);
	// Free-running system clock.
	always #50 clk = ~clk;
	irqal_host i_host (.clk(clk), .ds_mode(dsm), .ds_n(ds_n),
		.rd_n(rd_n), .wr_n(wr_n), .cs_n(cs_n), .ack_n(ack_n),
		.xack(xoe), .doe(doe), .dout(dout));
	// Device under test; bus strobes come from the host model.
	irqal_top i_dut (.CLK_SYS(clk), .RST_N(rst_n), .CE(ce),
		.CHAN_STATUS_LO(sl), .CHAN_STATUS_HI(sh), .PORT_IRQ_STATUS(ps),
		.CHAN_MASK_LO(ml), .CHAN_MASK_HI(16'h0000), .PORT_IRQ_MASK(8'h00),
		.PORT_IRQ_EN(pe), .IRQ_DRIVE_MODE(dm), .CASCADE_MODE(cas),
		.STROBE_BUS_MODE(dsm), .SLAVE_ADDR(sa), .VECTOR_BASE(VB),
		.DATA_STROBE_IN_N(ds_n), .RD_N(rd_n), .WR_N(wr_n), .CS_N(cs_n),
		.IRQ_ACK_IN_N(ack_n), .CHAIN_ENABLE_IN(cin), .CHAIN_ADDR_HI(1'b0),
		.IRQ_OUT(io), .IRQ_OE(ioe), .XFER_ACK_OUT_N(xan), .XFER_ACK_OE(xoe),
		.DATA_OUT(dout), .DATA_OE(doe), .CHAIN_ENABLE_OUT(ceo),
		.CHAIN_ADDR_LO_OE(), .GLOBAL_IRQ_STATUS(global_irq_status));
	////////////////////////////////////////
	task automatic wrap_up();
		if (error_cnt == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : wrap_up
	// Bounded wait for the request level; a timeout ends the run.
	task automatic wt(logic lvl);
		int n;
		for (n = 0; n < 20 && act !== lvl; n++) @(posedge clk);
		if (act !== lvl) begin
			error_cnt++;
			wrap_up();
		end
	endtask : wt
	task automatic quiet();
		repeat (10) @(posedge clk);
		`CHK(act, 1'b0)
	endtask : quiet
	function automatic int idx(int g);
		return g < 4 ? g * 8 : 8 + g * 4;
	endfunction : idx
	// Accepted acknowledge, then sources cleared.
	task automatic svc(int g);
		i_host.ack(acc, vo, v);
		`CHK(acc, 1'b1)
		`CHK(vo, 1'b1)
		`CHK(v, {VB[7:3], 3'(g)})
		{ps, sh, sl} <= '0;
		wt(1'b0);
	endtask : svc
	// Main sequence.
	initial begin
		repeat (16) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		`CHK(global_irq_status, 8'h00)
		foreach (gl[i]) begin
			{ps, sh, sl} <= 40'h1 << idx(gl[i]);
			wt(1'b1);
			`CHK(global_irq_status, 8'h01 << gl[i])
			svc(gl[i]);
		end
		{ps, sh, sl} <= (40'h1 << 36) | (40'h1 << 24);
		wt(1'b1);
		svc(3);
		foreach (ml3[i]) begin
			dm <= ml3[i];
			repeat (8) @(posedge clk);
			sl <= 16'h0001;
			wt(1'b1);
			`CHK(io, ml3[i] == IRQAL_DRV_PP_HIGH)
			svc(0);
		end
		sl <= 16'h0010;
		ml <= 16'h0010;
		quiet();
		ml <= 16'h0000;
		wt(1'b1);
		svc(0);
		pe <= 1'b0;
		ps <= 8'h01;
		quiet();
		pe <= 1'b1;
		wt(1'b1);
		svc(6);
		sa <= 2'h2;
		sl <= 16'h0001;
		wt(1'b1);
		i_host.ack(acc, vo, v);
		`CHK(acc, 1'b0)
		`CHK(vo, 1'b0)
		sa <= 2'h0;
		svc(0);
		cas <= IRQAL_CAS_DAISY;
		sl <= 16'h0001;
		quiet();
		cin <= 1'b1;
		wt(1'b1);
		`CHK(ceo, 1'b0)
		cin <= 1'b0;
		wt(1'b0);
		i_host.ack(acc, vo, v);
		`CHK(vo, 1'b0)
		cin <= 1'b1;
		wt(1'b1);
		svc(0);
		cas <= IRQAL_CAS_SLAVE;
		dsm <= 1'b0;
		sl <= 16'h0001;
		wt(1'b1);
		i_host.ack(acc, vo, v);
		`CHK(vo, 1'b0)
		`CHK(act, 1'b1)
		svc(0);
		// Register accesses in both bus modes.
		i_host.xfer(1'b1, acc);
		`CHK(acc, 1'b1)
		`CHK(xoe, 1'b0)
		dsm <= 1'b1;
		i_host.xfer(1'b0, acc);
		`CHK(acc, 1'b1)
		`CHK(xan, 1'b0)
		// A low enable freezes the summary while the source clears.
		sl <= 16'h0001;
		wt(1'b1);
		ce <= 1'b0;
		sl <= 16'h0000;
		repeat (10) @(posedge clk);
		`CHK(global_irq_status, 8'h01)
		ce <= 1'b1;
		wt(1'b0);
		wrap_up();
	end
endmodule : irqal_tb_top
